// [design/shift_move_instruction_exec.sv]
// Single-cycle executor for shift, copy, indirect load and literal ops.
`timescale 1ns/1ps
module shift_move_instruction_exec
  import shift_move_pkg::*;
(
  // Clock and reset.
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Decoded instruction.
  input  wire logic               i_valid,
  input  wire op_type             i_op,
  input  wire logic               i_dest,
  input  wire logic [7:0]         i_literal,
  input  wire logic               i_ptr_sel,
  input  wire upd_type            i_upd,
  input  wire logic [OFS_W-1:0]   i_offset,
  // Operand data from file or memory, same cycle.
  input  wire logic [7:0]         i_file_data,
  input  wire logic [7:0]         i_mem_data,
  // Memory and file access.
  output logic [PTR_W-1:0]        o_mem_addr,
  output logic                    o_file_we,
  output logic [7:0]              o_file_wdata,
  // Architectural state.
  output logic [7:0]              o_acc,
  output logic                    o_carry,
  output logic                    o_zero,
  output logic [BANK_W-1:0]       o_bank,
  output logic [PAGE_W-1:0]       o_page,
  output logic [PTR_W-1:0]        o_ptr0,
  output logic [PTR_W-1:0]        o_ptr1
);
  logic [7:0]       acc_q, acc_d;
  logic             carry_q, carry_d, zero_q, zero_d;
  logic [BANK_W-1:0] bank_q, bank_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [PTR_W-1:0] ptr_q [2];
  logic [PTR_W-1:0] ptr_d [2];
  logic [PTR_W-1:0] cur_ptr, inc_ptr, dec_ptr, new_ptr, addr;
  logic [PTR_W-1:0] ofs_ext;
  logic [7:0]       result;
  logic             wr_file;

  // Pointer arithmetic wraps naturally at sixteen bits.
  always_comb begin
    cur_ptr = ptr_q[i_ptr_sel];
    inc_ptr = cur_ptr + PTR_ONE;
    dec_ptr = cur_ptr - PTR_ONE;
    new_ptr = i_upd[0] ? dec_ptr : inc_ptr;
    ofs_ext = {{(PTR_W-OFS_W){i_offset[OFS_W-1]}}, i_offset};
    if (i_op == OP_IND_OFFSET) begin
      addr = cur_ptr + ofs_ext;
    end else if (i_upd[1]) begin
      addr = cur_ptr;
    end else begin
      addr = new_ptr;
    end
  end

  // Next state of all architectural registers.
  always_comb begin
    acc_d   = acc_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    bank_d  = bank_q;
    page_d  = page_q;
    ptr_d[0] = ptr_q[0];
    ptr_d[1] = ptr_q[1];
    result  = 8'h00;
    wr_file = 1'b0;
    if (i_valid) begin
      unique case (i_op)
        OP_SHIFT_RIGHT: begin
          result  = {1'b0, i_file_data[7:1]};
          carry_d = i_file_data[0];
          zero_d  = (result == 8'h00);
          wr_file = i_dest;
          if (!i_dest) acc_d = result;
        end
        OP_FILE_COPY: begin
          result  = i_file_data;
          zero_d  = (result == 8'h00);
          wr_file = i_dest;
          if (!i_dest) acc_d = result;
        end
        OP_IND_LOAD: begin
          acc_d  = i_mem_data;
          zero_d = (i_mem_data == 8'h00);
          ptr_d[i_ptr_sel] = new_ptr;
        end
        OP_IND_OFFSET: begin
          acc_d  = i_mem_data;
          zero_d = (i_mem_data == 8'h00);
        end
        OP_BANK_LIT: bank_d = i_literal[BANK_W-1:0];
        OP_PAGE_LIT: page_d = i_literal[PAGE_W-1:0];
        OP_ACC_LIT:  acc_d  = i_literal;
        OP_NONE: ;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q   <= ACC_RESET;
      carry_q <= FLAG_RESET;
      zero_q  <= FLAG_RESET;
      bank_q  <= BANK_RESET;
      page_q  <= PAGE_RESET;
      ptr_q[0] <= PTR_RESET;
      ptr_q[1] <= PTR_RESET;
    end else begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      bank_q  <= bank_d;
      page_q  <= page_d;
      ptr_q[0] <= ptr_d[0];
      ptr_q[1] <= ptr_d[1];
    end
  end

  assign o_mem_addr   = addr;
  assign o_file_we    = wr_file;
  assign o_file_wdata = result;
  assign o_acc   = acc_q;
  assign o_carry = carry_q;
  assign o_zero  = zero_q;
  assign o_bank  = bank_q;
  assign o_page  = page_q;
  assign o_ptr0  = ptr_q[0];
  assign o_ptr1  = ptr_q[1];

  // Checks on the executed behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_shift_carry_out: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT |=> o_carry == $past(i_file_data[0]))
    else $error("shift carry wrong");
  a_shift_to_acc: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT && !i_dest
    |=> o_acc == {1'b0, $past(i_file_data[7:1])})
    else $error("shift result wrong");
  a_shift_zero_flag: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT
    |=> o_zero == ($past(i_file_data[7:1]) == 7'h00))
    else $error("shift zero wrong");
  a_shift_writeback: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT && i_dest
    |-> o_file_we && o_file_wdata == {1'b0, i_file_data[7:1]})
    else $error("shift writeback wrong");
  a_shift_keeps_acc: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT && i_dest |=> $stable(o_acc))
    else $error("shift changed accumulator");
  a_shift_no_write: assert property (
    i_valid && i_op == OP_SHIFT_RIGHT && !i_dest |-> !o_file_we)
    else $error("shift wrote file");

  a_copy_writeback: assert property (
    i_valid && i_op == OP_FILE_COPY && i_dest
    |-> o_file_we && o_file_wdata == i_file_data)
    else $error("copy writeback wrong");
  a_copy_to_acc: assert property (
    i_valid && i_op == OP_FILE_COPY && !i_dest
    |=> o_acc == $past(i_file_data))
    else $error("copy result wrong");
  a_copy_zero_flag: assert property (
    i_valid && i_op == OP_FILE_COPY
    |=> o_zero == ($past(i_file_data) == 8'h00))
    else $error("copy zero wrong");

  a_load_acc_value: assert property (
    i_valid && i_op == OP_IND_LOAD |=> o_acc == $past(i_mem_data))
    else $error("load data wrong");
  a_load_zero_flag: assert property (
    i_valid && (i_op == OP_IND_LOAD || i_op == OP_IND_OFFSET)
    |=> o_zero == ($past(i_mem_data) == 8'h00))
    else $error("load zero wrong");
  a_load_keeps_carry: assert property (
    i_valid && (i_op == OP_IND_LOAD || i_op == OP_IND_OFFSET)
    |=> $stable(o_carry))
    else $error("load changed carry");
  a_load_other_ptr: assert property (
    i_valid && i_op == OP_IND_LOAD && !i_ptr_sel |=> $stable(o_ptr1))
    else $error("other pointer moved");
  a_pre_addr_mode: assert property (
    i_valid && i_op == OP_IND_LOAD && i_upd == UPD_PRE_INC && !i_ptr_sel
    |-> o_mem_addr == o_ptr0 + PTR_ONE)
    else $error("pre address wrong");
  a_pre_dec_addr: assert property (
    i_valid && i_op == OP_IND_LOAD && i_upd == UPD_PRE_DEC
    |-> o_mem_addr == (i_ptr_sel ? o_ptr1 : o_ptr0) - PTR_ONE)
    else $error("predec address wrong");
  a_post_addr_mode: assert property (
    i_valid && i_op == OP_IND_LOAD && i_upd[1]
    |-> o_mem_addr == (i_ptr_sel ? o_ptr1 : o_ptr0))
    else $error("post address wrong");
  a_post_dec_ptr: assert property (
    i_valid && i_op == OP_IND_LOAD && i_upd == UPD_POST_DEC && i_ptr_sel
    |=> o_ptr1 == $past(o_ptr1) - PTR_ONE)
    else $error("post dec wrong");
  a_inc_ptr_wrap: assert property (
    i_valid && i_op == OP_IND_LOAD && !i_upd[0] && !i_ptr_sel
    |=> o_ptr0 == $past(o_ptr0) + PTR_ONE)
    else $error("pointer increment wrong");

  a_offset_address: assert property (
    i_valid && i_op == OP_IND_OFFSET
    |-> o_mem_addr == (i_ptr_sel ? o_ptr1 : o_ptr0)
        + PTR_W'(signed'(i_offset)))
    else $error("offset address wrong");
  a_offset_acc_value: assert property (
    i_valid && i_op == OP_IND_OFFSET |=> o_acc == $past(i_mem_data))
    else $error("offset data wrong");
  a_offset_keeps_ptr: assert property (
    i_valid && i_op == OP_IND_OFFSET |=> $stable(o_ptr0) && $stable(o_ptr1))
    else $error("offset moved pointer");

  a_bank_no_flags: assert property (
    i_valid && i_op == OP_BANK_LIT
    |=> $stable(o_zero) && $stable(o_carry)
        && o_bank == $past(i_literal[BANK_W-1:0]))
    else $error("bank load wrong");
  a_page_load: assert property (
    i_valid && i_op == OP_PAGE_LIT
    |=> o_page == $past(i_literal[PAGE_W-1:0]) && $stable(o_zero))
    else $error("page load wrong");
  a_acc_literal: assert property (
    i_valid && i_op == OP_ACC_LIT
    |=> o_acc == $past(i_literal) && $stable(o_zero) && $stable(o_carry))
    else $error("literal load wrong");

  c_shift_to_file: cover property (
    i_valid && i_op == OP_SHIFT_RIGHT && i_dest);
  c_load_wrap: cover property (
    i_valid && i_op == OP_IND_LOAD && o_ptr0 == 16'hFFFF
    && i_upd == UPD_POST_INC && !i_ptr_sel);
  c_post_dec_sel: cover property (
    i_valid && i_op == OP_IND_LOAD && i_upd == UPD_POST_DEC && i_ptr_sel);
  c_offset_neg: cover property (
    i_valid && i_op == OP_IND_OFFSET && i_offset[OFS_W-1]);
  c_copy_zero: cover property (
    i_valid && i_op == OP_FILE_COPY && i_file_data == 8'h00);
endmodule : shift_move_instruction_exec

// [design/shift_move_pkg.sv]
// Package with constants and op codes of the shift and move executor.
package shift_move_pkg;
  localparam int PTR_W = 16;
  localparam int BANK_W = 5;
  localparam int PAGE_W = 7;
  localparam int OFS_W = 6;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_ONE = 16'h0001;
  localparam logic [BANK_W-1:0] BANK_RESET = 5'h00;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 7'h00;
  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_SHIFT_RIGHT = 3'b001,
    OP_FILE_COPY   = 3'b010,
    OP_IND_LOAD    = 3'b011,
    OP_IND_OFFSET  = 3'b100,
    OP_BANK_LIT    = 3'b101,
    OP_PAGE_LIT    = 3'b110,
    OP_ACC_LIT     = 3'b111
  } op_type;
  typedef enum logic [1:0] {
    UPD_PRE_INC  = 2'b00,
    UPD_PRE_DEC  = 2'b01,
    UPD_POST_INC = 2'b10,
    UPD_POST_DEC = 2'b11
  } upd_type;
endpackage : shift_move_pkg

// [verification/testbench.sv]
// Self-checking bench for the shift and move executor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  import shift_move_pkg::*;
  logic             i_clk = 0, i_rst = 1, i_valid = 0, i_dest = 0, i_ptr_sel = 0;
  op_type           i_op = OP_NONE;
  upd_type          i_upd = UPD_PRE_INC;
  logic [7:0]       i_literal = 0, i_file_data = 0, i_mem_data = 0;
  logic [OFS_W-1:0] i_offset = 0;
  logic [PTR_W-1:0] o_mem_addr, o_ptr0, o_ptr1, addr_s;
  logic             o_file_we, o_carry, o_zero, we_s;
  logic [7:0]       o_file_wdata, o_acc, wd_s;
  logic [BANK_W-1:0] o_bank;
  logic [PAGE_W-1:0] o_page;
  int               failures = 0, cmp_count = 0, cycles = 0;
  shift_move_instruction_exec uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_valid(i_valid), .i_op(i_op), .i_dest(i_dest), .i_literal(i_literal),
    .i_ptr_sel(i_ptr_sel), .i_upd(i_upd), .i_offset(i_offset),
    .i_file_data(i_file_data), .i_mem_data(i_mem_data),
    .o_mem_addr(o_mem_addr), .o_file_we(o_file_we),
    .o_file_wdata(o_file_wdata), .o_acc(o_acc), .o_carry(o_carry),
    .o_zero(o_zero), .o_bank(o_bank), .o_page(o_page), .o_ptr0(o_ptr0),
    .o_ptr1(o_ptr1));
  always #5 i_clk = ~i_clk;
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  // Issues one instruction, samples the combinational answer, then the state.
  task automatic run(op_type op, logic d, logic [7:0] lit, logic [7:0] fd,
    logic [7:0] md, logic sel, upd_type u, logic [OFS_W-1:0] ofs);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_dest <= d;
    i_literal <= lit;
    i_file_data <= fd;
    i_mem_data <= md;
    i_ptr_sel <= sel;
    i_upd <= u;
    i_offset <= ofs;
    @(negedge i_clk);
    addr_s = o_mem_addr;
    we_s = o_file_we;
    wd_s = o_file_wdata;
    @(posedge i_clk);
    i_valid <= 1'b0;
    @(negedge i_clk);
  endtask : run
  task automatic ck_ind(logic [15:0] ea, logic [15:0] p0, logic [15:0] p1,
    logic [7:0] md);
    `CHK("addr", ea, addr_s)
    `CHK("ptr0", p0, o_ptr0)
    `CHK("ptr1", p1, o_ptr1)
    `CHK("acc", md, o_acc)
    `CHK("zero", md == 8'h00, o_zero)
  endtask : ck_ind
  task automatic t_shift_copy;
    run(OP_SHIFT_RIGHT, 1'b0, 8'h00, 8'h81, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("acc", 8'h40, o_acc)
    `CHK("carry", 1'b1, o_carry)
    `CHK("zero", 1'b0, o_zero)
    `CHK("we", 1'b0, we_s)
    run(OP_SHIFT_RIGHT, 1'b1, 8'h00, 8'h01, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("we", 1'b1, we_s)
    `CHK("wdata", 8'h00, wd_s)
    `CHK("acc", 8'h40, o_acc)
    `CHK("zero", 1'b1, o_zero)
    run(OP_FILE_COPY, 1'b0, 8'h00, 8'hA5, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("acc", 8'hA5, o_acc)
    `CHK("zero", 1'b0, o_zero)
    run(OP_FILE_COPY, 1'b1, 8'h00, 8'h00, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("we", 1'b1, we_s)
    `CHK("wdata", 8'h00, wd_s)
    `CHK("acc", 8'hA5, o_acc)
    `CHK("zero", 1'b1, o_zero)
    $display("shift and copy test done");
  endtask : t_shift_copy
  task automatic t_indirect;
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h3C, 1'b0, UPD_PRE_INC, 6'h00);
    ck_ind(16'h0001, 16'h0001, 16'h0000, 8'h3C);
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, UPD_PRE_DEC, 6'h00);
    ck_ind(16'h0000, 16'h0000, 16'h0000, 8'h00);
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h11, 1'b0, UPD_POST_DEC, 6'h00);
    ck_ind(16'h0000, 16'hffff, 16'h0000, 8'h11);
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h22, 1'b0, UPD_POST_INC, 6'h00);
    ck_ind(16'hffff, 16'h0000, 16'h0000, 8'h22);
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h33, 1'b1, UPD_PRE_INC, 6'h00);
    ck_ind(16'h0001, 16'h0000, 16'h0001, 8'h33);
    run(OP_IND_OFFSET, 1'b0, 8'h00, 8'h00, 8'h44, 1'b1, UPD_PRE_INC, 6'h20);
    ck_ind(16'hffe1, 16'h0000, 16'h0001, 8'h44);
    run(OP_IND_OFFSET, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, UPD_PRE_INC, 6'h1f);
    ck_ind(16'h0020, 16'h0000, 16'h0001, 8'h00);
    run(OP_IND_LOAD, 1'b0, 8'h00, 8'h00, 8'h55, 1'b1, UPD_POST_DEC, 6'h00);
    ck_ind(16'h0001, 16'h0000, 16'h0000, 8'h55);
    $display("indirect test done");
  endtask : t_indirect
  task automatic t_literal;
    run(OP_SHIFT_RIGHT, 1'b1, 8'h00, 8'h01, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    run(OP_BANK_LIT, 1'b0, 8'hff, 8'h00, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("bank", 5'h1f, o_bank)
    `CHK("flags", 2'b11, {o_carry, o_zero})
    run(OP_PAGE_LIT, 1'b0, 8'hff, 8'h00, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("page", 7'h7f, o_page)
    `CHK("flags", 2'b11, {o_carry, o_zero})
    run(OP_ACC_LIT, 1'b0, 8'h5a, 8'h00, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("acc", 8'h5a, o_acc)
    `CHK("flags", 2'b11, {o_carry, o_zero})
    run(OP_NONE, 1'b0, 8'h00, 8'h00, 8'h00, 1'b0, UPD_PRE_INC, 6'h00);
    `CHK("acc", 8'h5a, o_acc)
    $display("literal test done");
  endtask : t_literal
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    `CHK("reset", 8'h00, o_acc)
    t_shift_copy();
    t_indirect();
    t_literal();
    final_report();
  end
endmodule : testbench
